// [design/xiem_consts.svh]
// constants for the extended interrupt enable mask block
// assumes inclusion by bare name from design files
`ifndef XIEM_CONSTS_SVH
`define XIEM_CONSTS_SVH

// register index of the mask word; its byte address is four times the index
`define XIEM_MASK_OFFSET   8'hE6
`define XIEM_MASK_RESET    8'h00
`define XIEM_BIT_TIMER3    3'h7
`define XIEM_BIT_COMP1     3'h6
`define XIEM_BIT_COMP0     3'h5
`define XIEM_BIT_PCA       3'h4
`define XIEM_BIT_CONV      3'h3
`define XIEM_BIT_WINDOW    3'h2
`define XIEM_BIT_BUSFN     3'h1
`define XIEM_BIT_TWOWIRE   3'h0
`define XIEM_RESP_OKAY     2'h0
`define XIEM_RESP_DECERR   2'h3

`endif

// [design/xiem_pkg.sv]
// types for the extended interrupt enable mask block
// assumes the constants header is included where offsets are needed
package xiem_pkg;
   typedef logic [7:0] xiem_mask_t;
   typedef logic [1:0] xiem_resp_t;
endpackage

// [design/xiem_gate.sv]
// per-source request gating: one and-gate per mask bit
// assumes raw requests already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module xiem_gate
   import xiem_pkg::*;
(
   input  wire xiem_mask_t mask,      // enable bits
   input  wire xiem_mask_t raw_req,   // grouped source requests
   output logic [7:0]      gated_req  // requests passed to core
);
   // one gate per source bit
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : gen_gate
         assign gated_req[g] = mask[g] & raw_req[g];
      end
   endgenerate
endmodule
`default_nettype wire

// [design/xiem_top.sv]
// extended interrupt enable mask: register over axi4-lite, gates eight sources
// assumes source flags are synchronous to clk (peripherals share the core clock)
// Behaviour
// - bit 7 passes timer3 low or high overflow requests, else blocks both
// - bit 6 passes comparator one rise or fall requests, else blocks
// - bit 5 passes comparator zero rise or fall requests, else blocks
// - bit 4 gates all counter array requests as one group
// - bit 3 gates the conversion done request
// - bit 2 gates the window match request
// - bit 1 gates all bus function controller requests as one group
`timescale 1ns/10ps
`default_nettype none
`include "xiem_consts.svh"
module xiem_top
   import xiem_pkg::*;
(
   input  wire logic        clk,                        // 100 MHz clock
   input  wire logic        resetn,                     // async reset, low
   input  wire logic [9:0]  s_axi_awaddr,               // write address
   input  wire logic        s_axi_awvalid,              // write address valid
   output logic             s_axi_awready,              // write address ready
   input  wire logic [31:0] s_axi_wdata,                // write data
   input  wire logic [3:0]  s_axi_wstrb,                // write strobes
   input  wire logic        s_axi_wvalid,               // write data valid
   output logic             s_axi_wready,               // write data ready
   output logic [1:0]       s_axi_bresp,                // write response
   output logic             s_axi_bvalid,               // write response valid
   input  wire logic        s_axi_bready,               // write response ready
   input  wire logic [9:0]  s_axi_araddr,               // read address
   input  wire logic        s_axi_arvalid,              // read address valid
   output logic             s_axi_arready,              // read address ready
   output logic [31:0]      s_axi_rdata,                // read data
   output logic [1:0]       s_axi_rresp,                // read response
   output logic             s_axi_rvalid,               // read data valid
   input  wire logic        s_axi_rready,               // read data ready
   input  wire logic        timer3_low_overflow_flag,   // timer3 low byte
   input  wire logic        timer3_high_overflow_flag,  // timer3 high byte
   input  wire logic        comparator1_rise_flag,      // comparator one rise
   input  wire logic        comparator1_fall_flag,      // comparator one fall
   input  wire logic        comparator0_rise_flag,      // comparator zero rise
   input  wire logic        comparator0_fall_flag,      // comparator zero fall
   input  wire logic        counter_array_req,          // any counter array request
   input  wire logic        conversion_done_flag,       // conversion complete
   input  wire logic        window_match_flag,          // window compare hit
   input  wire logic        bus_function_req,           // any bus function request
   input  wire logic        two_wire_req,               // any two wire request
   output logic [7:0]       irq_req,                    // gated requests to core
   output logic [7:0]       irq_mask                    // current mask value
);
   xiem_mask_t extended_irq_enable_one;
   xiem_mask_t next_mask;
   logic       aw_held;
   logic       w_held;
   logic [9:0] aw_addr;
   logic [31:0] w_data;
   logic       w_lane0;

   // write channel: accept address and data in either order
   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire aw_have  = aw_held | aw_take;
   wire w_have   = w_held | w_take;
   wire [9:0] aw_cur = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] w_cur = w_held ? w_data : s_axi_wdata;
   wire w_strb0  = w_held ? w_lane0 : s_axi_wstrb[0];
   wire do_write = aw_have & w_have & ~s_axi_bvalid;
   wire wr_hit   = aw_cur[9:2] == `XIEM_MASK_OFFSET;    // word index match
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign next_mask = (do_write & wr_hit & w_strb0) ? w_cur[7:0] : extended_irq_enable_one;

   // read channel decode
   wire rd_take = s_axi_arvalid & s_axi_arready;
   wire rd_hit  = s_axi_araddr[9:2] == `XIEM_MASK_OFFSET;
   assign s_axi_arready = ~s_axi_rvalid;

   // capture halves of a write that arrive apart
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 10'h000;
         w_data  <= 32'h0;
         w_lane0 <= 1'b0;
      end
      else
      begin
         aw_held <= aw_have & ~do_write;
         w_held  <= w_have & ~do_write;
         if (aw_take)
            aw_addr <= s_axi_awaddr;
         if (w_take)
         begin
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
      end
   end

   // mask register and write response
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         extended_irq_enable_one <= `XIEM_MASK_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end
      else
      begin
         extended_irq_enable_one <= next_mask;
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `XIEM_RESP_OKAY : `XIEM_RESP_DECERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read response, upper bits read zero
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end
      else if (rd_take)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_hit ? {24'h0, extended_irq_enable_one} : 32'h0;
         s_axi_rresp  <= rd_hit ? `XIEM_RESP_OKAY : `XIEM_RESP_DECERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // group each source's flags into one raw request per mask bit
   xiem_mask_t raw_req;
   assign raw_req[`XIEM_BIT_TIMER3]  = timer3_low_overflow_flag | timer3_high_overflow_flag;
   assign raw_req[`XIEM_BIT_COMP1]   = comparator1_rise_flag | comparator1_fall_flag;
   assign raw_req[`XIEM_BIT_COMP0]   = comparator0_rise_flag | comparator0_fall_flag;
   assign raw_req[`XIEM_BIT_PCA]     = counter_array_req;
   assign raw_req[`XIEM_BIT_CONV]    = conversion_done_flag;
   assign raw_req[`XIEM_BIT_WINDOW]  = window_match_flag;
   assign raw_req[`XIEM_BIT_BUSFN]   = bus_function_req;
   assign raw_req[`XIEM_BIT_TWOWIRE] = two_wire_req;

   logic [7:0] gated;
   // per-bit mask gating
   xiem_gate u_gate (
      .mask      (extended_irq_enable_one),
      .raw_req   (raw_req),
      .gated_req (gated)
   );

   // registered outputs to the core
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_req  <= 8'h00;
         irq_mask <= 8'h00;
      end
      else
      begin
         irq_req  <= gated;
         irq_mask <= extended_irq_enable_one;
      end
   end

   // assertions
   chk_timer3_gate: assert property (@(posedge clk) disable iff (!resetn)
      irq_req[7] == $past(extended_irq_enable_one[7] & (timer3_low_overflow_flag | timer3_high_overflow_flag)))
      else $error("timer3 gating wrong");
   chk_comp1_gate: assert property (@(posedge clk) disable iff (!resetn)
      irq_req[6] == $past(extended_irq_enable_one[6] & (comparator1_rise_flag | comparator1_fall_flag)))
      else $error("comparator one gating wrong");
   chk_comp0_gate: assert property (@(posedge clk) disable iff (!resetn)
      irq_req[5] == $past(extended_irq_enable_one[5] & (comparator0_rise_flag | comparator0_fall_flag)))
      else $error("comparator zero gating wrong");
   chk_pca_block: assert property (@(posedge clk) disable iff (!resetn)
      !extended_irq_enable_one[4] |=> !irq_req[4])
      else $error("counter array not blocked");
   chk_conv_pass: assert property (@(posedge clk) disable iff (!resetn)
      (extended_irq_enable_one[3] && conversion_done_flag) |=> irq_req[3])
      else $error("conversion request lost");
   chk_window_gate: assert property (@(posedge clk) disable iff (!resetn)
      irq_req[2] |-> $past(extended_irq_enable_one[2] && window_match_flag))
      else $error("window request leaked");
   chk_busfn_gate: assert property (@(posedge clk) disable iff (!resetn)
      irq_req[1] == $past(extended_irq_enable_one[1] & bus_function_req))
      else $error("bus function gating wrong");
   chk_twowire_gate: assert property (@(posedge clk) disable iff (!resetn)
      irq_req[0] == $past(extended_irq_enable_one[0] & two_wire_req))
      else $error("two wire gating wrong");
   chk_mask_write: assert property (@(posedge clk) disable iff (!resetn)
      (do_write && wr_hit && w_strb0) |=> ##1 irq_mask == $past(w_cur[7:0], 2))
      else $error("mask write not stored");

   // writes that miss the word or lane zero must leave the mask alone
   chk_miss_kept: assert property (@(posedge clk) disable iff (!resetn)
      (do_write && !wr_hit) |=> $stable(extended_irq_enable_one))
      else $error("unmapped write changed mask");
   chk_lane_kept: assert property (@(posedge clk) disable iff (!resetn)
      (do_write && !w_strb0) |=> $stable(extended_irq_enable_one))
      else $error("write without lane zero changed mask");

   // every complete write gets its response on the next edge
   chk_bresp_due: assert property (@(posedge clk) disable iff (!resetn)
      do_write |=> s_axi_bvalid)
      else $error("write response missing");

   // read data carries the mask as it stood when the address was taken
   chk_read_data: assert property (@(posedge clk) disable iff (!resetn)
      (rd_take && rd_hit) |=> s_axi_rdata == {24'h0, $past(extended_irq_enable_one)})
      else $error("read data not the mask");
endmodule
`default_nettype wire

// [bench/xiem_core_model.sv]
// core-side model: latches every gated request it sees while clear_seen is low
// assumes irq_req is a level synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module xiem_core_model
   import xiem_pkg::*;
(
   input  wire logic       clk,        // core clock
   input  wire logic       resetn,     // async reset, low
   input  wire logic       clear_seen, // forget latched requests
   input  wire xiem_mask_t irq_req,    // gated requests
   output var xiem_mask_t  seen        // sticky record of requests
);
   // sticky capture so a one-cycle leak is missed only in a cycle where clear_seen is high
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         seen <= 8'h00;
      else if (clear_seen)
         seen <= 8'h00;
      else
         seen <= seen | irq_req;
endmodule
`default_nettype wire

// [bench/xiem_top_tb.sv]
// self-checking bench for the interrupt enable mask
// assumes design files and core model compiled first
`timescale 1ns/10ps
`default_nettype none
`include "xiem_consts.svh"
module xiem_top_tb;
   import xiem_pkg::*;
   logic             clk, resetn, awv, wv, bry, arv, rry, clr;
   logic [9:0]       awa, ara;
   logic [31:0]      wd, d;
   logic [3:0]       ws;
   logic [1:0]       r;
   logic [10:0]      src;
   wire logic        awr, wr, bv, arr, rv;
   wire logic [1:0]  br, rr;
   wire logic [31:0] rd;
   wire xiem_mask_t  irq, msk, seen;
   int               miscompares, total_checks;
   // byte address of the mask word: four times its index
   localparam logic [9:0] mask_addr = {`XIEM_MASK_OFFSET, 2'h0};
   xiem_top xiem_top_inst (.clk(clk), .resetn(resetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .timer3_low_overflow_flag(src[0]), .timer3_high_overflow_flag(src[1]), .comparator1_rise_flag(src[2]),
      .comparator1_fall_flag(src[3]), .comparator0_rise_flag(src[4]), .comparator0_fall_flag(src[5]),
      .counter_array_req(src[6]), .conversion_done_flag(src[7]), .window_match_flag(src[8]),
      .bus_function_req(src[9]), .two_wire_req(src[10]), .irq_req(irq), .irq_mask(msk));
   xiem_core_model xiem_core_model_inst (.clk(clk), .resetn(resetn), .clear_seen(clr), .irq_req(irq),
      .seen(seen));
   // compare and count
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   // one write: address and data offered together
   task automatic axw(input logic [9:0] a, input logic [31:0] dv, input logic [3:0] s);
      logic pa, pw, ta, tw, tb;
      pa = 1;
      pw = 1;
      awa <= a;
      wd <= dv;
      ws <= s;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      // ready read mid-cycle when settled, acted on at the next rising edge
      while (pa | pw)
      begin
         @(negedge clk);
         ta = pa & (awr === 1'b1);
         tw = pw & (wr === 1'b1);
         @(posedge clk);
         if (ta)
         begin
            pa = 0;
            awv <= 0;
         end
         if (tw)
         begin
            pw = 0;
            wv <= 0;
         end
      end
      // bready stays high; the response is taken at the edge it meets bvalid
      do
      begin
         @(negedge clk);
         tb = (bv === 1'b1);
         r = br;
         @(posedge clk);
      end
      while (!tb);
   endtask
   // one read, rready left high
   task automatic axr(input logic [9:0] a);
      logic t;
      ara <= a;
      arv <= 1;
      rry <= 1;
      do
      begin
         @(negedge clk);
         t = (arr === 1'b1);
         @(posedge clk);
      end
      while (!t);
      arv <= 0;
      do
      begin
         @(negedge clk);
         t = (rv === 1'b1);
         d = rd;
         r = rr;
         @(posedge clk);
      end
      while (!t);
   endtask
   // mask reads zero after reset
   task automatic t_reset;
      axr(mask_addr);
      chk("reset mask", d, 32'h0);
      chk("irq_mask", {24'h0, msk}, 32'h0);
   endtask
   // each source alone, own bit cleared then own bit set
   task automatic t_gate;
      int g;
      logic [7:0] m;
      logic [31:0] e;
      for (int i = 0; i < 11; i++)
         for (int p = 0; p < 2; p++)
         begin
            g = (i < 6) ? 7 - i / 2 : 10 - i;
            m = p ? 8'hFF : ~(8'h01 << g);
            e = p ? 32'h1 << g : 32'h0;
            axw(mask_addr, {24'h0, m}, 4'hF);
            chk("mask bresp", {30'h0, r}, 32'h0);
            axr(mask_addr);
            chk("mask readback", d, {24'h0, m});
            chk("mask rresp", {30'h0, r}, 32'h0);
            clr <= 1;
            @(posedge clk);
            clr <= 0;
            src <= 11'h001 << i;
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("irq_req", {24'h0, irq}, e);
            chk("seen", {24'h0, seen}, e);
            chk("irq_mask", {24'h0, msk}, {24'h0, m});
            @(posedge clk);
            src <= 11'h000;
         end
   endtask
   // unmapped word and upper lanes leave mask alone
   task automatic t_bad;
      axw(10'h3C0, 32'h0000_0012, 4'hF);
      chk("bad bresp", {30'h0, r}, 32'h3);
      axr(10'h3C0);
      chk("bad rresp", {30'h0, r}, 32'h3);
      chk("bad rdata", d, 32'h0);
      axw(mask_addr, 32'h0000_0034, 4'hE);
      axr(mask_addr);
      chk("mask kept", d, 32'hFF);
   endtask
   // reset in mid run clears the mask while every source is active
   task automatic t_midrst;
      axw(mask_addr, 32'h0000_005A, 4'hF);
      @(negedge clk);
      chk("irq_mask before reset", {24'h0, msk}, 32'h5A);
      @(posedge clk);
      resetn <= 0;
      src <= 11'h7FF;
      repeat (3) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      @(negedge clk);
      chk("irq_mask after reset", {24'h0, msk}, 32'h0);
      chk("irq_req after reset", {24'h0, irq}, 32'h0);
      @(posedge clk);
      src <= 11'h000;
      axr(mask_addr);
      chk("mask after reset", d, 32'h0);
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // clock
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // watchdog
   initial
   begin
      #50000;
      miscompares++;
      final_report();
   end
   // main sequence
   initial
   begin
      {resetn, awv, wv, bry, arv, rry, clr, awa, ara, wd, ws, src} = '0;
      repeat (3) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      t_reset();
      t_gate();
      t_bad();
      t_midrst();
      final_report();
   end
endmodule
`default_nettype wire
